/* common/ldp_defines.svh */
// shared constants for the lpddr pin link: widths, command codes, phases
// assumes inclusion by bare name from any file of the link
`ifndef LDP_DEFINES_SVH
`define LDP_DEFINES_SVH

// ----------------------------------------
// widths and sizes
// ----------------------------------------
`define LDP_CA_W       10
`define LDP_DW         16
`define LDP_AW         4
`define LDP_BL         4
`define LDP_FIFO_DEPTH 32
`define LDP_CMD_W      3
`define LDP_LANE_W     8

// ----------------------------------------
// command codes carried on the rising half of ca
// ----------------------------------------
`define LDP_CMD_WR     3'h1
`define LDP_CMD_RD     3'h2

// ----------------------------------------
// host divider: link clock is clk / 4, high while count[1] is set
// ----------------------------------------
`define LDP_PH_LAUNCH  2'h0
`define LDP_PH_MID     2'h2
`define LDP_CK_BIT     1

`endif

/* common/ldp_if.sv */
// pin-level link between memory controller and memory device
// assumes one instance joins both ends
`timescale 1ns/1ps
`include "ldp_defines.svh"
interface ldp_if #(parameter int DW = `LDP_DW) ();
    localparam int NB = DW / `LDP_LANE_W;

    // ----------------------------------------
    // controller driven, input only at the device
    // ----------------------------------------
    logic                 ck_t;
    logic                 ck_c;
    logic                 cke;
    logic                 cs_n;
    logic [`LDP_CA_W-1:0] ca;
    logic [NB-1:0]        dm;

    // ----------------------------------------
    // two-way pins, one driver set per end
    // ----------------------------------------
    logic [DW-1:0]        h_dq_o;
    logic                 h_dq_oe;
    logic [NB-1:0]        h_dqs_t_o;
    logic [NB-1:0]        h_dqs_c_o;
    logic                 h_dqs_oe;
    logic [DW-1:0]        d_dq_o;
    logic                 d_dq_oe;
    logic [NB-1:0]        d_dqs_t_o;
    logic [NB-1:0]        d_dqs_c_o;
    logic                 d_dqs_oe;
    logic [DW-1:0]        dq;
    logic [NB-1:0]        dqs_t;
    logic [NB-1:0]        dqs_c;

    // idle bus rests low, complement strobe high
    assign dq    = d_dq_oe  ? d_dq_o    : (h_dq_oe  ? h_dq_o    : '0);
    assign dqs_t = d_dqs_oe ? d_dqs_t_o : (h_dqs_oe ? h_dqs_t_o : '0);
    assign dqs_c = d_dqs_oe ? d_dqs_c_o : (h_dqs_oe ? h_dqs_c_o : '1);

    modport host (
        output ck_t, ck_c, cke, cs_n, ca, dm,
        output h_dq_o, h_dq_oe, h_dqs_t_o, h_dqs_c_o, h_dqs_oe,
        input  dq, dqs_t, dqs_c
    );
    modport dev (
        input  ck_t, ck_c, cke, cs_n, ca, dm, dq, dqs_t, dqs_c,
        output d_dq_o, d_dq_oe, d_dqs_t_o, d_dqs_c_o, d_dqs_oe
    );
endinterface : ldp_if

/* common/ldp_pkg.sv */
// types shared by both ends of the lpddr pin link
// assumes ldp_defines.svh on the include path
package ldp_pkg;

    // ----------------------------------------
    // state types
    // ----------------------------------------
    typedef enum logic [1:0] {DS_IDLE, DS_WR, DS_RD} ldp_dst_t;
    typedef enum logic [1:0] {HS_IDLE, HS_CMD, HS_WR, HS_RD} ldp_hst_t;

endpackage : ldp_pkg

/* rtl/ldp_dev.sv */
// memory device end of the pin link: command capture, power save, data strobes
// assumes the controller end drives ck_t/ck_c; rst held for several link clocks
// What this block does
// R01 - ca captured on both clock edges
// R02 - cs_n and cke sampled on positive edge only
// R03 - edges are crossings of the differential clock
// R04 - cke low disables drivers and ends any burst; clocks and inputs keep running
// R05 - cke transitions enter and leave power save
// R06 - command decoded from cke, cs_n and ca
// R07 - ca driven only by the controller
// R08 - data bus two-way, 16 or 32 bits
// R09 - strobe travels with data both directions
// R10 - read strobe edge aligned, write strobe centred
// R11 - one strobe pair per byte lane
// R12 - masked write beats are not stored
// R13 - mask sampled on both strobe edges
// R14 - one mask bit per byte lane
`timescale 1ns/1ps
`include "ldp_defines.svh"
module ldp_dev #(
    parameter int DW = `LDP_DW,
    parameter int AW = `LDP_AW,
    parameter int BL = `LDP_BL
) (
    // link pins
    ldp_if.dev              link,
    // reset, synchronised into the link clock here
    input wire logic        rst,
    // status
    output ldp_pkg::ldp_dst_t state,
    output logic            pwr_down,
    output logic            cke_seen
);
    import ldp_pkg::*;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NB    = DW / `LDP_LANE_W;
    localparam int DEPTH = 2 ** AW;
    localparam int BW    = $clog2(BL + 1);
    localparam logic [BW-1:0] BL_B   = BW'(BL);
    localparam logic [BW-1:0] BL_M1  = BW'(BL - 1);

    typedef struct packed {
        logic                           rst_s1;
        logic                           rst_s2;
        logic                           cke_r;
        logic                           csn_r;
        logic [`LDP_CA_W-1:0]           car_r;
        logic                           pd_r;
        ldp_dst_t                       st_r;
        logic [AW-1:0]                  adr_r;
        logic [BW-1:0]                  beat_r;
        logic [NB-1:0]                  dqs_last_r;
        logic                           oe_r;
        logic                           dqs_r;
        logic                           dqsc_r;
        logic [DW-1:0]                  dq_r;
        logic [DEPTH-1:0][DW-1:0]       mem_r;
    } ldp_dev_st_t;

    ldp_dev_st_t          s;
    ldp_dev_st_t          n;
    logic [`LDP_CA_W-1:0] caf_r;
    logic [DW-1:0]        wdq_r;
    logic [NB-1:0]        wdm_r;
    logic [NB-1:0]        wdqs_r;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [AW-1:0] ldp_idx(input logic [AW-1:0] a, input logic [BW-1:0] b);
        return a + AW'(b);
    endfunction : ldp_idx

    // ----------------------------------------
    // negative crossing: rising complement clock
    // ----------------------------------------
    // host moves dq and dqs a quarter period off this edge
    always_ff @(posedge link.ck_c) begin // R03
        caf_r <= link.ca; // R01
        if (s.rst_s2) begin
            wdq_r  <= '0;
            wdm_r  <= '0;
            wdqs_r <= '0;
        end else begin
            wdq_r  <= link.dq;
            wdm_r  <= link.dm; // R13
            wdqs_r <= link.dqs_t; // R13
        end
    end

    // ----------------------------------------
    // positive crossing: main state
    // ----------------------------------------
    always_comb begin
        n        = s;
        n.rst_s1 = rst;
        n.rst_s2 = s.rst_s1;
        n.cke_r  = link.cke; // R02
        n.csn_r  = link.cs_n; // R02
        n.car_r  = link.ca; // R01
        if (s.cke_r && !link.cke) begin
            n.pd_r = 1'b1; // R05
        end else if (!s.cke_r && link.cke) begin
            n.pd_r = 1'b0; // R05
        end
        unique case (s.st_r)
            DS_IDLE: begin
                n.oe_r = 1'b0;
                if (s.cke_r && !s.csn_r) begin // R06
                    n.adr_r      = caf_r[AW-1:0];
                    n.beat_r     = '0;
                    n.dqs_last_r = wdqs_r;
                    if (s.car_r[`LDP_CMD_W-1:0] == `LDP_CMD_WR) begin // R06
                        n.st_r = DS_WR;
                    end else if (s.car_r[`LDP_CMD_W-1:0] == `LDP_CMD_RD) begin // R06
                        n.st_r   = DS_RD;
                        n.oe_r   = 1'b1; // R09
                        n.dqs_r  = 1'b0;
                        n.dqsc_r = 1'b1;
                    end
                end
            end
            DS_WR: begin
                // lane 0 paces the burst, each lane stores on its own strobe
                if (wdqs_r[0] != s.dqs_last_r[0]) begin
                    n.dqs_last_r = wdqs_r;
                    for (int l = 0; l < NB; l++) begin
                        if (wdqs_r[l] != s.dqs_last_r[l] && !wdm_r[l]) begin // R11 R12 R14
                            n.mem_r[ldp_idx(s.adr_r, s.beat_r)][l*`LDP_LANE_W +: `LDP_LANE_W] =
                                wdq_r[l*`LDP_LANE_W +: `LDP_LANE_W];
                        end
                    end
                    n.beat_r = s.beat_r + 1'b1;
                    if (s.beat_r == BL_M1) begin
                        n.st_r = DS_IDLE;
                    end
                end
            end
            DS_RD: begin
                if (s.beat_r == BL_B) begin
                    n.oe_r = 1'b0;
                    n.st_r = DS_IDLE;
                end else begin
                    // data and strobe leave on the same edge
                    n.dq_r   = s.mem_r[ldp_idx(s.adr_r, s.beat_r)]; // R10
                    n.dqs_r  = ~s.dqs_r; // R10
                    n.dqsc_r = s.dqs_r;
                    n.beat_r = s.beat_r + 1'b1;
                end
            end
        endcase
        // a burst cut by cke low is lost: drivers go quiet one link clock after cke is sampled low
        if (!s.cke_r) begin
            n.st_r = DS_IDLE; // R04
            n.oe_r = 1'b0; // R04
        end
        if (s.rst_s2) begin
            n        = '0;
            n.st_r   = DS_IDLE;
            n.dqsc_r = 1'b1;
            n.rst_s1 = rst;
            n.rst_s2 = s.rst_s1;
        end
    end

    always_ff @(posedge link.ck_t) begin // R03
        s <= n;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign link.d_dq_o    = s.dq_r; // R08
    assign link.d_dq_oe   = s.oe_r; // R08
    assign link.d_dqs_t_o = {NB{s.dqs_r}}; // R11
    assign link.d_dqs_c_o = {NB{s.dqsc_r}}; // R11
    assign link.d_dqs_oe  = s.oe_r; // R09
    assign state          = s.st_r;
    assign pwr_down       = s.pd_r;
    assign cke_seen       = s.cke_r;

endmodule : ldp_dev

/* rtl/ldp_host.sv */
// controller end of the pin link and its read data fifo
// assumes clk at 200 MHz; link clock made here by dividing clk by four
`timescale 1ns/1ps
`include "ldp_defines.svh"

// ----------------------------------------
// read data fifo
// ----------------------------------------
module ldp_fifo #(
    parameter int W     = `LDP_DW,
    parameter int DEPTH = `LDP_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // fill side
    input  wire logic                       in_valid,
    input  wire logic [W-1:0]               in_data,
    output logic                            in_ready,
    // drain side
    output logic                            out_valid,
    output logic [W-1:0]                    out_data,
    input  wire logic                       out_ready,
    // fill level of the array
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem_r;
        logic [PW-1:0]           wp_r;
        logic [PW-1:0]           rp_r;
        logic [CW-1:0]           cnt_r;
        logic                    ov_r;
        logic [W-1:0]            od_r;
    } ldp_fifo_st_t;

    ldp_fifo_st_t s;
    ldp_fifo_st_t n;
    logic         push;
    logic         pop;

    always_comb begin
        n    = s;
        push = in_valid && (s.cnt_r != FULL);
        pop  = (s.cnt_r != '0) && (!s.ov_r || out_ready);
        if (push) begin
            n.mem_r[s.wp_r] = in_data;
            n.wp_r          = s.wp_r + 1'b1;
        end
        if (pop) begin
            n.od_r = s.mem_r[s.rp_r];
            n.ov_r = 1'b1;
            n.rp_r = s.rp_r + 1'b1;
        end else if (out_ready) begin
            n.ov_r = 1'b0;
        end
        n.cnt_r = s.cnt_r + CW'(push) - CW'(pop);
        if (rst) begin
            n = '0;
        end
    end

    always_ff @(posedge clk) begin
        s <= n;
    end

    assign in_ready  = (s.cnt_r != FULL);
    assign out_valid = s.ov_r;
    assign out_data  = s.od_r;
    assign level     = s.cnt_r;

endmodule : ldp_fifo

// ----------------------------------------
// controller end
// ----------------------------------------
module ldp_host #(
    parameter int DW = `LDP_DW,
    parameter int AW = `LDP_AW,
    parameter int BL = `LDP_BL
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // link pins
    ldp_if.host                       link,
    // request
    input  wire logic                 req_valid,
    input  wire logic                 req_write,
    input  wire logic [AW-1:0]        req_addr,
    input  wire logic [BL*DW-1:0]     req_wdata,
    input  wire logic [BL*(DW/8)-1:0] req_wmask,
    output logic                      req_ready,
    // power save request, level
    input  wire logic                 pd_req,
    // read data stream
    output logic [DW-1:0]             rd_data,
    output logic                      rd_valid,
    input  wire logic                 rd_ready
);
    import ldp_pkg::*;

    localparam int NB  = DW / `LDP_LANE_W;
    localparam int BW  = $clog2(BL + 1);
    localparam int CW  = $clog2(`LDP_FIFO_DEPTH + 1);
    localparam logic [BW-1:0] BL_B  = BW'(BL);
    localparam logic [BW-1:0] BL_M1 = BW'(BL - 1);
    localparam logic [CW-1:0] ROOM  = CW'(`LDP_FIFO_DEPTH - BL);

    typedef struct packed {
        logic [1:0]           cnt_r;
        logic                 ck_t_r;
        logic                 ck_c_r;
        logic                 cke_r;
        logic                 cs_n_r;
        logic [`LDP_CA_W-1:0] ca_r;
        logic [`LDP_CA_W-1:0] caf_r;
        ldp_hst_t             st_r;
        logic                 wr_r;
        logic [BL*DW-1:0]     wd_r;
        logic [BL*NB-1:0]     wm_r;
        logic [BW-1:0]        beat_r;
        logic [DW-1:0]        dq_r;
        logic [NB-1:0]        dm_r;
        logic                 dq_oe_r;
        logic                 dqs_r;
        logic                 dqs_oe_r;
        logic                 req_ready_r;
        logic [DW-1:0]        dq_s1;
        logic [DW-1:0]        dq_s2;
        logic                 dqs_s1;
        logic                 dqs_s2;
        logic                 dqs_p;
    } ldp_host_st_t;

    ldp_host_st_t  s;
    ldp_host_st_t  n;
    logic          la;
    logic          mid;
    logic          push;
    logic          f_ready;
    logic [CW-1:0] f_level;

    always_comb begin
        n             = s;
        push          = 1'b0;
        n.cnt_r       = s.cnt_r + 2'h1;
        n.ck_t_r      = n.cnt_r[`LDP_CK_BIT]; // R03
        n.ck_c_r      = ~n.cnt_r[`LDP_CK_BIT];
        la            = (s.cnt_r == `LDP_PH_LAUNCH);
        mid           = (s.cnt_r == `LDP_PH_MID);
        n.req_ready_r = 1'b0;
        n.dq_s1       = link.dq;
        n.dq_s2       = s.dq_s1;
        n.dqs_s1      = link.dqs_t[0];
        n.dqs_s2      = s.dqs_s1;
        n.dqs_p       = s.dqs_s2;
        unique case (s.st_r)
            HS_IDLE: begin
                if (la) begin
                    // single rate pins move only a quarter period before the rising edge
                    n.cs_n_r = 1'b1; // R02
                    n.ca_r   = '0; // R07
                    n.cke_r  = !pd_req; // R02 R05
                    if (req_valid && s.cke_r && !pd_req && f_ready &&
                        (req_write || f_level <= ROOM)) begin
                        n.cs_n_r      = 1'b0;
                        n.ca_r        = `LDP_CA_W'(req_write ? `LDP_CMD_WR : `LDP_CMD_RD);
                        n.caf_r       = `LDP_CA_W'(req_addr);
                        n.wr_r        = req_write;
                        n.wd_r        = req_wdata;
                        n.wm_r        = req_wmask;
                        n.req_ready_r = 1'b1;
                        n.st_r        = HS_CMD;
                    end
                end
            end
            HS_CMD: begin
                if (mid) begin
                    n.ca_r = s.caf_r; // R01
                end else if (la) begin
                    n.cs_n_r = 1'b1;
                    n.ca_r   = '0;
                    n.beat_r = '0;
                    if (s.wr_r) begin
                        n.st_r     = HS_WR;
                        n.dq_oe_r  = 1'b1; // R08
                        n.dqs_oe_r = 1'b1; // R09
                        n.dqs_r    = 1'b0;
                        n.dq_r     = s.wd_r[DW-1:0];
                        n.dm_r     = s.wm_r[NB-1:0]; // R12 R14
                    end else begin
                        n.st_r = HS_RD;
                    end
                end
            end
            HS_WR: begin
                if (mid) begin
                    n.dqs_r  = ~s.dqs_r; // R10
                    n.beat_r = s.beat_r + 1'b1;
                end else if (la) begin
                    if (s.beat_r == BL_B) begin
                        n.dq_oe_r  = 1'b0;
                        n.dqs_oe_r = 1'b0;
                        n.dm_r     = '0;
                        n.st_r     = HS_IDLE;
                    end else begin
                        n.dq_r = s.wd_r[s.beat_r*DW +: DW];
                        n.dm_r = s.wm_r[s.beat_r*NB +: NB]; // R12 R14
                    end
                end
            end
            HS_RD: begin
                // dq and dqs cross together
                if (s.dqs_s2 != s.dqs_p) begin // R09 R11
                    push     = 1'b1;
                    n.beat_r = s.beat_r + 1'b1;
                    if (s.beat_r == BL_M1) begin
                        n.st_r = HS_IDLE;
                    end
                end
            end
        endcase
        if (rst) begin
            n        = '0;
            n.st_r   = HS_IDLE;
            n.cs_n_r = 1'b1;
            n.ck_c_r = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        s <= n;
    end

    ldp_fifo #(.W(DW), .DEPTH(`LDP_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_data   (s.dq_s2),
        .in_ready  (f_ready),
        .out_valid (rd_valid),
        .out_data  (rd_data),
        .out_ready (rd_ready),
        .level     (f_level)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign link.ck_t      = s.ck_t_r;
    assign link.ck_c      = s.ck_c_r;
    assign link.cke       = s.cke_r;
    assign link.cs_n      = s.cs_n_r;
    assign link.ca        = s.ca_r; // R07
    assign link.dm        = s.dm_r;
    assign link.h_dq_o    = s.dq_r;
    assign link.h_dq_oe   = s.dq_oe_r;
    assign link.h_dqs_t_o = {NB{s.dqs_r}};
    assign link.h_dqs_c_o = {NB{~s.dqs_r}};
    assign link.h_dqs_oe  = s.dqs_oe_r;
    assign req_ready      = s.req_ready_r;

endmodule : ldp_host

/* verification/ddr_sdram_pin_interface_tb_top.sv */
// self-checking bench: controller end and device end joined by one link
// assumes design files and headers on the include path
`timescale 1ns/1ps
`include "ldp_defines.svh"
module ddr_sdram_pin_interface_tb_top;
    import ldp_pkg::*;
    localparam int DW = `LDP_DW;
    localparam int NB = DW / 8;
    localparam int BL = `LDP_BL;
    localparam int MW = BL * NB;
    // ----------------------------------------
    // stimulus and model state
    // ----------------------------------------
    logic                 clk       = 1'b0;
    logic                 rst       = 1'b1;
    logic                 dev_rst   = 1'b1;
    logic                 req_valid = 1'b0;
    logic                 req_write = 1'b0;
    logic [`LDP_AW-1:0]   req_addr  = '0;
    logic [BL*DW-1:0]     req_wdata = '0;
    logic [MW-1:0]        req_wmask = '0;
    logic                 pd_req    = 1'b0;
    logic                 rd_ready  = 1'b0;
    logic                 drain_en  = 1'b0;
    logic                 req_ready;
    logic [DW-1:0]        rd_data;
    logic                 rd_valid;
    logic                 pwr_down;
    logic                 taken;
    logic [DW-1:0]        mem [16] = '{default: '0};
    logic [DW-1:0]        exp_q [$];
    integer               seed      = 73836;
    int                   n_errors  = 0;
    int                   compares  = 0;

    always #2.5 clk = ~clk;

    ldp_if #(.DW(DW)) link_if ();
    ldp_host #(.DW(DW)) ldp_host_inst (.clk(clk), .rst(rst), .link(link_if.host),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_wmask(req_wmask), .req_ready(req_ready),
        .pd_req(pd_req), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready));
    ldp_dev #(.DW(DW)) ldp_dev_inst (.link(link_if.dev), .rst(dev_rst), .state(),
        .pwr_down(pwr_down), .cke_seen());
    ldp_monitor #(.DW(DW)) ldp_monitor_inst (.clk(clk), .rst(rst), .dev_rst(dev_rst),
        .ck_t(link_if.ck_t), .ck_c(link_if.ck_c), .cke(link_if.cke), .cs_n(link_if.cs_n),
        .ca(link_if.ca), .dm(link_if.dm), .h_dq_oe(link_if.h_dq_oe),
        .h_dqs_oe(link_if.h_dqs_oe), .d_dq_oe(link_if.d_dq_oe),
        .d_dqs_oe(link_if.d_dqs_oe), .dq(link_if.dq), .dqs_t(link_if.dqs_t),
        .dqs_c(link_if.dqs_c));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic results;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // a lane keeps its old byte when its mask bit is set
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                            input logic [DW-1:0] nw, input logic [NB-1:0] m);
        logic [DW-1:0] r;
        r = old;
        for (int l = 0; l < NB; l++)
            if (!m[l]) r[l*8 +: 8] = nw[l*8 +: 8];
        return r;
    endfunction : merge

    task automatic request(input logic wr, input logic [`LDP_AW-1:0] a,
                           input logic [BL*DW-1:0] d, input logic [MW-1:0] m, input int bound);
        logic [`LDP_AW-1:0] w;
        req_valid = 1'b1;
        req_write = wr;
        req_addr  = a;
        req_wdata = d;
        req_wmask = m;
        taken     = 1'b0;
        for (int i = 0; i < bound && !taken; i++) begin
            @(negedge clk);
            taken = (req_ready === 1'b1);
        end
        req_valid = 1'b0;
        for (int b = 0; b < BL && taken; b++) begin
            w = a + `LDP_AW'(b);
            if (wr) mem[w] = merge(mem[w], d[b*DW +: DW], m[b*NB +: NB]);
            else exp_q.push_back(mem[w]);
        end
        @(negedge clk);
    endtask : request

    // must be taken, else the run ends
    task automatic req_ok(input logic wr, input logic [`LDP_AW-1:0] a,
                          input logic [BL*DW-1:0] d, input logic [MW-1:0] m);
        request(wr, a, d, m, 200);
        check(DW'(taken), DW'(1'b1));
        if (!taken) results();
    endtask : req_ok

    task automatic drain;
        drain_en = 1'b1;
        for (int i = 0; i < 4000 && exp_q.size() != 0; i++)
            @(negedge clk);
        check(DW'(exp_q.size()), '0);
        if (exp_q.size() != 0) results();
    endtask : drain

    task automatic wait_pd(input logic v);
        for (int i = 0; i < 200 && pwr_down !== v; i++)
            @(negedge clk);
        check(DW'(pwr_down), DW'(v));
        if (pwr_down !== v) results();
    endtask : wait_pd

    // random stalls; a pop is checked before the edge that takes it
    always @(negedge clk) begin
        rd_ready = drain_en & 1'($random(seed));
        if (rd_valid === 1'b1 && rd_ready)
            check(rd_data, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [NB-1:0] lm;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        dev_rst = 1'b0;
        repeat (8) @(negedge clk);
        drain_en = 1'b1;
        // each lane masked alone, then none, across the top word wrap
        for (int l = 0; l <= NB; l++) begin
            lm = NB'(1 << l);
            req_ok(1'b1, 4'hf, {$random(seed), $random(seed)}, {BL{lm}});
        end
        req_ok(1'b1, 4'h2, {$random(seed), $random(seed)}, '1);
        req_ok(1'b0, 4'he, '0, '0);
        req_ok(1'b0, 4'h2, '0, '0);
        for (int k = 0; k < 24; k++)
            req_ok(1'($random(seed)), 4'($random(seed)), {$random(seed), $random(seed)},
                   MW'($random(seed)));
        drain();
        // power save: clock enable low, requests refused, then leave
        pd_req = 1'b1;
        wait_pd(1'b1);
        check(DW'(link_if.cke), '0);
        request(1'b0, 4'h0, '0, '0, 40);
        check(DW'(taken), '0);
        pd_req = 1'b0;
        wait_pd(1'b0);
        // fill the read buffer until the controller refuses
        drain_en = 1'b0;
        taken = 1'b1;
        for (int k = 0; k < 10 && taken; k++)
            request(1'b0, 4'($random(seed)), '0, '0, 80);
        check(DW'(taken), '0);
        check(DW'(exp_q.size() >= `LDP_FIFO_DEPTH), DW'(1'b1));
        drain();
        for (int k = 0; k < 16; k += BL)
            req_ok(1'b0, 4'(k), '0, '0);
        drain();
        results();
    end
endmodule : ddr_sdram_pin_interface_tb_top

/* verification/ldp_monitor.sv */
// assertions on the pin link between the controller end and the device end
// assumes an instance beside the link interface, sampled on clk
`timescale 1ns/1ps
`include "ldp_defines.svh"
module ldp_monitor #(
    parameter int DW = 16
) (
    // clocks and resets
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 dev_rst,
    // controller driven pins
    input wire logic                 ck_t,
    input wire logic                 ck_c,
    input wire logic                 cke,
    input wire logic                 cs_n,
    input wire logic [`LDP_CA_W-1:0] ca,
    input wire logic [DW/8-1:0]      dm,
    // two-way pins and their enables
    input wire logic                 h_dq_oe,
    input wire logic                 h_dqs_oe,
    input wire logic                 d_dq_oe,
    input wire logic                 d_dqs_oe,
    input wire logic [DW-1:0]        dq,
    input wire logic [DW/8-1:0]      dqs_t,
    input wire logic [DW/8-1:0]      dqs_c
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    // link clock is made from clk, so clk sees every link edge
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || dev_rst);

    // launch slot: link clock low now, rising at the next clk
    sequence s_launch;
        !ck_t ##1 $rose(ck_t);
    endsequence

    a_ck_diff: assert property (ck_c == !ck_t)
        else $error("clock pair not complementary");
    a_cke_launch: assert property ($changed(cke) |-> s_launch)
        else $error("cke moved off launch slot");
    a_cs_launch: assert property ($changed(cs_n) |-> s_launch)
        else $error("cs_n moved off launch slot");
    a_ca_half: assert property ($changed(ca) |=> $changed(ck_t))
        else $error("ca not launched before a link edge");
    a_one_driver: assert property (!(d_dq_oe && h_dq_oe))
        else $error("both ends drive the data bus");
    a_wr_centre: assert property (h_dqs_oe && $past(h_dqs_oe) && $changed(dqs_t) |-> $stable(dq))
        else $error("write strobe moved with data");
    a_rd_align: assert property (d_dqs_oe && $past(d_dqs_oe) && $changed(dq) |-> $changed(dqs_t))
        else $error("read data moved alone");
    a_rd_strobe: assert property (d_dq_oe |-> d_dqs_oe && dqs_c == ~dqs_t)
        else $error("read data without strobe pair");
    a_dm_idle: assert property (!h_dq_oe |-> dm == '0)
        else $error("mask set outside a write");
    a_dev_quiet: assert property (!cke [*6] |-> !d_dq_oe && !d_dqs_oe)
        else $error("device drives with cke low");
    c_read: cover property (d_dq_oe ##1 !d_dq_oe);
endmodule : ldp_monitor
